// *** pesq_ctrl.sv ***
// module: per-port egress shaping, gate schedule, drop policy and membership mask
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pesq_ctrl import pesq_pkg::*; #(
	parameter int NQ = 4,
	parameter int NEV = 128,
	parameter int SECOND_CYCLES = PESQ_SECOND_CYCLES
) (
	input wire logic sys_clk, // 200 MHz clock
	input wire logic rst, // async reset, high
	input wire pesq_bus_t bus, // register strobes, address, write data
	output logic [31:0] rd_data, // read data, cycle after read strobe
	input wire logic pps_pulse, // ptp pulse-per-second, one cycle
	input wire logic [63:0] ptp_time, // current ptp reference time
	input wire logic dest_congested, // destination congestion level
	input wire logic [2:0] frame_prio, // priority of the current ingress frame
	output logic flow_ctrl, // flow control toward this source port
	output logic drop_frame, // discard current ingress frame
	output logic [6:0] fwd_allow, // forward permission per port, bit0 = port 1
	output logic [NQ-1:0] gate_open, // per queue: gated traffic may start
	output logic [NQ-1:0] guard_band, // per queue: guard band active
	output logic cut_through_en, // gated cut-through permitted
	output logic [NQ-1:0] credit_active, // per queue: credit shaper selected
	output logic [NQ*16-1:0] credit_inc // per queue credit increment
);
	localparam int QW = $clog2(NQ);
	localparam int EW = $clog2(NEV);
	logic [QW-1:0] queue_index;
	logic [1:0] shaper_mode [NQ];
	logic [15:0] credit_val [NQ];
	logic [7:0] gate_ctrl;
	logic [EW-1:0] event_index;
	logic [31:0] sched [NEV];
	logic [63:0] ref_time;
	pesq_drop_t drop_mode;
	logic [6:0] member_mask;
	logic [EW-1:0] ev_ptr;
	logic [28:0] cyc_count;
	logic running;
	logic sched_open;
	logic sched_guard;
	logic [31:0] sec_count;
	logic ref_crossed;
	logic restart;
	pesq_event_t cur_ev;
	logic ev_hit;
	logic wr_queue_index;
	logic wr_gate_ctrl;
	logic wr_event_index;
	logic wr_event_entry;
	logic wr_ref_time;
	logic wr_drop_ctrl;
	logic wr_member_mask;

	assign cur_ev = sched[ev_ptr];

	// one decoded strobe per global register keeps each of their always_ff to a single concern; per-queue registers decode the address inline
	assign wr_queue_index = bus.wr && bus.addr == PESQ_ADDR_QUEUE_INDEX;
	assign wr_gate_ctrl = bus.wr && bus.addr == PESQ_ADDR_GATE_CTRL;
	assign wr_event_index = bus.wr && bus.addr == PESQ_ADDR_EVENT_INDEX;
	assign wr_event_entry = bus.wr && bus.addr == PESQ_ADDR_EVENT_ENTRY;
	assign wr_ref_time = bus.wr && bus.addr == PESQ_ADDR_REF_TIME;
	assign wr_drop_ctrl = bus.wr && bus.addr == PESQ_ADDR_DROP_CTRL;
	assign wr_member_mask = bus.wr && bus.addr == PESQ_ADDR_MEMBER_MASK;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			queue_index <= '0;
		end else if (wr_queue_index) begin
			queue_index <= bus.wdata[QW-1:0];
		end
	end

	// reserved bits are dropped on write so they always read back zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gate_ctrl <= 8'h00;
		end else if (wr_gate_ctrl) begin
			gate_ctrl <= {bus.wdata[7:6], 4'h0, bus.wdata[1:0]};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			event_index <= '0;
		end else if (wr_event_index) begin
			event_index <= bus.wdata[EW-1:0];
		end
	end

	// only the low word is writable; the upper word stays zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ref_time <= 64'h0;
		end else if (wr_ref_time) begin
			ref_time <= {32'h0, bus.wdata};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drop_mode <= PESQ_DROP_NONE;
		end else if (wr_drop_ctrl) begin
			drop_mode <= pesq_drop_t'(bus.wdata[1:0]);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			member_mask <= PESQ_MASK_RESET;
		end else if (wr_member_mask) begin
			member_mask <= bus.wdata[6:0];
		end
	end

	// per-queue registers reached through the queue index
	genvar q;
	generate
		for (q = 0; q < NQ; q++) begin : g_queue
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					shaper_mode[q] <= 2'h0;
					credit_val[q] <= PESQ_CREDIT_RESET;
				end else if (bus.wr && queue_index == QW'(q)) begin
					if (bus.addr == PESQ_ADDR_SHAPER_MODE)
						shaper_mode[q] <= bus.wdata[1:0];
					if (bus.addr == PESQ_ADDR_CREDIT_INC)
						credit_val[q] <= bus.wdata[15:0];
				end
			end
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					gate_open[q] <= 1'b0;
					guard_band[q] <= 1'b0;
					credit_active[q] <= 1'b0;
					credit_inc[q*16 +: 16] <= PESQ_CREDIT_RESET;
				end else begin
					if (shaper_mode[q] == PESQ_SHAPE_TAS) begin
						gate_open[q] <= gate_ctrl[PESQ_CTRL_RESTRICT_BIT] ? sched_open : 1'b1;
						guard_band[q] <= sched_guard;
					end else begin
						gate_open[q] <= 1'b1;
						guard_band[q] <= 1'b0;
					end
					credit_active[q] <= shaper_mode[q] == PESQ_SHAPE_CBS;
					credit_inc[q*16 +: 16] <= credit_val[q];
				end
			end
		end
	endgenerate

	// schedule memory has no reset: software loads it before enabling a reference
	always_ff @(posedge sys_clk) begin
		if (wr_event_entry)
			sched[event_index] <= bus.wdata;
	end

	// internal one-second pulse for free-running mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sec_count <= 32'h0;
		end else if (sec_count == 32'(SECOND_CYCLES - 1)) begin
			sec_count <= 32'h0;
		end else begin
			sec_count <= sec_count + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ref_crossed <= 1'b0;
		end else begin
			ref_crossed <= ptp_time >= ref_time;
		end
	end

	always_comb begin
		case (gate_ctrl[1:0])
			PESQ_REF_TIME: restart = (ptp_time >= ref_time) && !ref_crossed;
			PESQ_REF_PPS: restart = pps_pulse;
			PESQ_REF_FREE: restart = sec_count == 32'(SECOND_CYCLES - 1);
			default: restart = 1'b0;
		endcase
	end

	// schedule walker: a restart arms it, clearing the reference select parks it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			running <= 1'b0;
		end else if (gate_ctrl[1:0] == PESQ_REF_NONE) begin
			running <= 1'b0;
		end else if (restart) begin
			running <= 1'b1;
		end
	end

	assign ev_hit = running && cur_ev.time_val == cyc_count;

	// the cycle count keeps rising past an entry; a repeat, a restart or a cleared reference select winds it back
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ev_ptr <= '0;
			cyc_count <= 29'h0;
		end else if (gate_ctrl[1:0] == PESQ_REF_NONE || restart) begin
			ev_ptr <= '0;
			cyc_count <= 29'h0;
		end else if (ev_hit && cur_ev.code == PESQ_EV_REPEAT) begin
			ev_ptr <= '0;
			cyc_count <= 29'h0;
		end else if (ev_hit) begin
			// reserved codes only move the pointer on
			ev_ptr <= ev_ptr + EW'(1);
			cyc_count <= cyc_count + 29'h1;
		end else if (running) begin
			cyc_count <= cyc_count + 29'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sched_open <= 1'b0;
			sched_guard <= 1'b0;
		end else if (gate_ctrl[1:0] == PESQ_REF_NONE) begin
			sched_open <= 1'b0;
			sched_guard <= 1'b0;
		end else if (ev_hit && !restart) begin
			case (cur_ev.code)
				PESQ_EV_OPEN: begin
					sched_open <= 1'b1;
					sched_guard <= 1'b0;
				end
				PESQ_EV_GUARD: sched_guard <= 1'b1;
				PESQ_EV_CLOSE: begin
					sched_open <= 1'b0;
					sched_guard <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cut_through_en <= 1'b0;
		end else begin
			cut_through_en <= gate_ctrl[PESQ_CTRL_CUT_BIT];
		end
	end

	// plain copy of the mask: no tag or table lookup takes part
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fwd_allow <= PESQ_MASK_RESET;
		end else begin
			fwd_allow <= member_mask;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flow_ctrl <= 1'b0;
		end else begin
			flow_ctrl <= drop_mode == PESQ_DROP_NONE && dest_congested;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drop_frame <= 1'b0;
		end else begin
			case (drop_mode)
				PESQ_DROP_P0: drop_frame <= dest_congested && frame_prio == 3'h0;
				PESQ_DROP_P01: drop_frame <= dest_congested && frame_prio <= 3'h1;
				PESQ_DROP_P012: drop_frame <= dest_congested && frame_prio <= 3'h2;
				default: drop_frame <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= 32'h0;
		end else if (bus.rd) begin
			case (bus.addr)
				PESQ_ADDR_QUEUE_INDEX: rd_data <= 32'(queue_index);
				PESQ_ADDR_SHAPER_MODE: rd_data <= 32'(shaper_mode[queue_index]);
				PESQ_ADDR_CREDIT_INC: rd_data <= 32'(credit_val[queue_index]);
				PESQ_ADDR_GATE_CTRL: rd_data <= 32'(gate_ctrl);
				PESQ_ADDR_EVENT_INDEX: rd_data <= 32'(event_index);
				PESQ_ADDR_EVENT_ENTRY: rd_data <= sched[event_index];
				PESQ_ADDR_REF_TIME: rd_data <= ref_time[31:0];
				PESQ_ADDR_DROP_CTRL: rd_data <= 32'(drop_mode);
				PESQ_ADDR_MEMBER_MASK: rd_data <= 32'(member_mask);
				PESQ_ADDR_GATE_STATUS: rd_data <= {running, sched_guard, sched_open, 22'h0,
					7'(ev_ptr)};
				default: rd_data <= 32'h0;
			endcase
		end else begin
			rd_data <= 32'h0;
		end
	end
endmodule

// *** pesq_pkg.sv ***
// package: register map, field layout and types for the port egress shaping/queue control block
// Contract
// - each egress queue holds a 16-bit credit increment, reset 0x2000 (12.5 percent)
// - control bit 7 set permits gated-traffic cut-through, clear disables it
// - restricted bit 6 set holds gated packets until a scheduled open period
// - restricted bit clear lets gated packets start at any moment
// - reference select 11 starts cycle when reference time crossed; 00 means none
// - reference select 10 restarts the cycle on every pulse-per-second event
// - reference select 01 runs free, restarting on internal one-second pulse
// - event entry: code in bits 31:29, time in bits 28:0 in clocks
// - code 000 closes the gate for time-aware traffic
// - drop mode 00 drops nothing and asserts flow control under congestion
// - modes 01/10/11 drop priorities 0, 0-1, 0-2 and disable flow control
// - 7-bit forwarding membership mask, all ones at reset, set bit allows
// - mask bit zero controls port one, bit one port two, ascending
// - membership mask applies independently of any VLAN tag or table
// - gating and credit apply only when queue shaper mode matches: 10 or 01
package pesq_pkg;
	localparam int PESQ_AW = 8;
	localparam logic [7:0] PESQ_ADDR_QUEUE_INDEX = 8'h00;
	localparam logic [7:0] PESQ_ADDR_SHAPER_MODE = 8'h04;
	localparam logic [7:0] PESQ_ADDR_CREDIT_INC = 8'h08;
	localparam logic [7:0] PESQ_ADDR_GATE_CTRL = 8'h0c;
	localparam logic [7:0] PESQ_ADDR_EVENT_INDEX = 8'h10;
	localparam logic [7:0] PESQ_ADDR_EVENT_ENTRY = 8'h14;
	localparam logic [7:0] PESQ_ADDR_REF_TIME = 8'h18;
	localparam logic [7:0] PESQ_ADDR_DROP_CTRL = 8'h1c;
	localparam logic [7:0] PESQ_ADDR_MEMBER_MASK = 8'h20;
	localparam logic [7:0] PESQ_ADDR_GATE_STATUS = 8'h24;
	localparam logic [15:0] PESQ_CREDIT_RESET = 16'h2000;
	localparam logic [6:0] PESQ_MASK_RESET = 7'h7f;
	localparam int PESQ_CTRL_CUT_BIT = 7;
	localparam int PESQ_CTRL_RESTRICT_BIT = 6;
	localparam int PESQ_EV_CODE_HI = 31;
	localparam int PESQ_EV_CODE_LO = 29;
	localparam int PESQ_EV_TIME_HI = 28;
	localparam logic [1:0] PESQ_SHAPE_CBS = 2'h1;
	localparam logic [1:0] PESQ_SHAPE_TAS = 2'h2;
	localparam logic [1:0] PESQ_REF_NONE = 2'h0;
	localparam logic [1:0] PESQ_REF_FREE = 2'h1;
	localparam logic [1:0] PESQ_REF_PPS = 2'h2;
	localparam logic [1:0] PESQ_REF_TIME = 2'h3;
	localparam logic [2:0] PESQ_EV_CLOSE = 3'h0;
	localparam logic [2:0] PESQ_EV_GUARD = 3'h1;
	localparam logic [2:0] PESQ_EV_OPEN = 3'h2;
	localparam logic [2:0] PESQ_EV_REPEAT = 3'h7;
	localparam int PESQ_SECOND_NS = 1000000000;
	localparam int PESQ_CLK_NS = 5;
	localparam int PESQ_SECOND_CYCLES = PESQ_SECOND_NS / PESQ_CLK_NS;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pesq_bus_t;
	typedef struct packed {
		logic [2:0] code;
		logic [28:0] time_val;
	} pesq_event_t;
	typedef enum logic [1:0] {
		PESQ_DROP_NONE,
		PESQ_DROP_P0,
		PESQ_DROP_P01,
		PESQ_DROP_P012
	} pesq_drop_t;
endpackage

// *** pesq_ctrl_asserts.sv ***
// checker: port-level assertions for the shaping and queue control block
`timescale 1ns/1ps
module pesq_ctrl_asserts import pesq_pkg::*; #(parameter int NQ = 4) (
	input wire logic sys_clk, // clock
	input wire logic rst, // reset
	input wire pesq_bus_t bus, // register bus
	input wire logic [31:0] rd_data, // read data
	input wire logic dest_congested, // congestion
	input wire logic [2:0] frame_prio, // frame priority
	input wire logic flow_ctrl, // pause source
	input wire logic drop_frame, // discard frame
	input wire logic [6:0] fwd_allow, // membership
	input wire logic cut_through_en, // cut-through
	input wire logic [NQ*16-1:0] credit_inc // increments
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_wr(logic [7:0] a);
		bus.wr && bus.addr == a;
	endsequence
	a_drop_flow_excl: assert property (!(flow_ctrl && drop_frame))
		else $error("flow control and drop together");
	a_flow_cause: assert property (flow_ctrl |-> $past(dest_congested))
		else $error("flow control without congestion");
	a_drop_cause: assert property (drop_frame |-> $past(dest_congested) && $past(frame_prio) <= 3'h2)
		else $error("drop without cause");
	a_read_quiet: assert property (!bus.rd |=> rd_data == 32'h0)
		else $error("read data outside read slot");
	a_mask_follow: assert property (s_wr(PESQ_ADDR_MEMBER_MASK) |-> ##2 fwd_allow == $past(bus.wdata[6:0], 2))
		else $error("mask output does not follow write");
	a_cut_follow: assert property (s_wr(PESQ_ADDR_GATE_CTRL) |-> ##2 cut_through_en == $past(bus.wdata[7], 2))
		else $error("cut-through does not follow write");
	a_credit_reset: assert property ($fell(rst) |-> credit_inc == {NQ{PESQ_CREDIT_RESET}})
		else $error("credit increment reset value wrong");
	a_mask_reset: assert property ($fell(rst) |-> fwd_allow == PESQ_MASK_RESET && !cut_through_en)
		else $error("mask or cut-through reset value wrong");
endmodule
bind pesq_ctrl pesq_ctrl_asserts #(.NQ(NQ)) u_chk (.sys_clk(sys_clk), .rst(rst), .bus(bus),
	.rd_data(rd_data), .dest_congested(dest_congested), .frame_prio(frame_prio),
	.flow_ctrl(flow_ctrl), .drop_frame(drop_frame), .fwd_allow(fwd_allow),
	.cut_through_en(cut_through_en), .credit_inc(credit_inc));

// *** port_egress_shaping_queue_ctrl_bench.sv ***
// testbench: drop policy rows, registers and gate schedule of the shaping block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module port_egress_shaping_queue_ctrl_bench import pesq_pkg::*; ();
	logic sys_clk = 0, rst = 1, pps_pulse = 0, dest_congested = 0;
	logic [2:0] frame_prio = 0;
	logic [63:0] ptp_time = 0;
	pesq_bus_t bus = '0;
	logic [31:0] rd_data;
	logic flow_ctrl, drop_frame, cut_through_en, seen_open, seen_guard;
	logic [6:0] fwd_allow;
	logic [3:0] gate_open, guard_band, credit_active;
	logic [63:0] credit_inc;
	int bad_count = 0, checked = 0;
	// {mode, congested, priority, expected flow control, expected drop}
	logic [7:0] rows [10] = '{8'h22, 8'h00, 8'h3e, 8'h61, 8'h64, 8'ha5, 8'ha8, 8'he9, 8'hec, 8'hc0};
	logic [31:0] ev [4] = '{{PESQ_EV_OPEN, 29'd5}, {PESQ_EV_GUARD, 29'd10},
		{PESQ_EV_CLOSE, 29'd15}, {PESQ_EV_REPEAT, 29'd20}};
	// one-second pulse shortened so the free-running restart shows in a short run
	pesq_ctrl #(.NQ(4), .NEV(128), .SECOND_CYCLES(50)) dut_u (.sys_clk(sys_clk), .rst(rst),
		.bus(bus), .rd_data(rd_data), .pps_pulse(pps_pulse), .ptp_time(ptp_time),
		.dest_congested(dest_congested), .frame_prio(frame_prio), .flow_ctrl(flow_ctrl),
		.drop_frame(drop_frame), .fwd_allow(fwd_allow), .gate_open(gate_open),
		.guard_band(guard_band), .cut_through_en(cut_through_en),
		.credit_active(credit_active), .credit_inc(credit_inc));
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk) bus <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk) bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk) bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge sys_clk) bus <= '0;
		#1 `CHK(rd_data, e)
	endtask
	task automatic watch(input int n);
		seen_open = 1'b0;
		seen_guard = 1'b0;
		repeat (n) begin
			tick(1);
			seen_open |= gate_open[0];
			seen_guard |= guard_band[0];
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(PESQ_ADDR_DROP_CTRL, {30'h0, rows[i][7:6]});
			@(posedge sys_clk) {dest_congested, frame_prio} <= rows[i][5:2];
			tick(2);
			`CHK(flow_ctrl, rows[i][1])
			`CHK(drop_frame, rows[i][0])
		end
		$display("test drop policy done");
		rd(PESQ_ADDR_MEMBER_MASK, 32'h7f);
		rd(PESQ_ADDR_CREDIT_INC, 32'h2000);
		rd(8'hfc, 32'h0);
		wr(PESQ_ADDR_MEMBER_MASK, 32'hffff_ff55);
		tick(1);
		`CHK(fwd_allow, 7'h55)
		rd(PESQ_ADDR_MEMBER_MASK, 32'h55);
		wr(PESQ_ADDR_QUEUE_INDEX, 32'h2);
		wr(PESQ_ADDR_SHAPER_MODE, 32'h1);
		wr(PESQ_ADDR_CREDIT_INC, 32'h1234);
		tick(1);
		`CHK(credit_inc, {16'h2000, 16'h1234, 16'h2000, 16'h2000})
		`CHK(credit_active, 4'h4)
		rd(PESQ_ADDR_CREDIT_INC, 32'h1234);
		wr(PESQ_ADDR_GATE_CTRL, 32'h80);
		tick(1);
		`CHK(cut_through_en, 1'b1)
		$display("test registers done");
		wr(PESQ_ADDR_QUEUE_INDEX, 32'h0);
		wr(PESQ_ADDR_SHAPER_MODE, 32'h2);
		wr(PESQ_ADDR_GATE_CTRL, 32'h0);
		tick(1);
		`CHK(gate_open, 4'hf)
		wr(PESQ_ADDR_GATE_CTRL, 32'h40);
		tick(1);
		`CHK(gate_open, 4'he)
		foreach (ev[i]) begin
			wr(PESQ_ADDR_EVENT_INDEX, 32'(i));
			wr(PESQ_ADDR_EVENT_ENTRY, ev[i]);
		end
		rd(PESQ_ADDR_EVENT_ENTRY, ev[3]);
		wr(PESQ_ADDR_GATE_CTRL, 32'h42);
		@(posedge sys_clk) pps_pulse <= 1'b1;
		@(posedge sys_clk) pps_pulse <= 1'b0;
		watch(40);
		`CHK({seen_open, seen_guard}, 2'b11)
		wr(PESQ_ADDR_GATE_CTRL, 32'h40);
		wr(PESQ_ADDR_GATE_CTRL, 32'h41);
		watch(120);
		`CHK({seen_open, seen_guard}, 2'b11)
		wr(PESQ_ADDR_GATE_CTRL, 32'h40);
		wr(PESQ_ADDR_REF_TIME, 32'h100);
		wr(PESQ_ADDR_GATE_CTRL, 32'h43);
		@(posedge sys_clk) ptp_time <= 64'h200;
		watch(40);
		`CHK({seen_open, seen_guard}, 2'b11)
		$display("test gate schedule done");
		@(posedge sys_clk) rst <= 1'b1;
		tick(1);
		`CHK(fwd_allow, 7'h7f)
		`CHK(credit_inc, {4{16'h2000}})
		@(posedge sys_clk) rst <= 1'b0;
		rd(PESQ_ADDR_MEMBER_MASK, 32'h7f);
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
